// >>> core/lcd_frame_rate_contrast_ctrl.sv
// Summary of operation
// - Reserved frame-rate bits 7,3 read zero
// - Tap field picks N from 16 to 4096
// - Divide field adds D equal code plus one
// - Segment clock is source over 2N over D
// - Frame is K*N*D source ticks, K 8/6
// - Drive code picks on-time or half period
// - On-time capped at half the spacing between segment edges
// - Static or blank forces half-period on-time
// - Always-on bit keeps drivers on continuously
// - Level code maps 2.60V plus 0.05V steps
// - New contrast level taken at frame start
// - Source select picks system or async clock
// - Duty code sets K: third gives six
`timescale 1ns/1ps
`default_nettype none
module lcd_frame_rate_contrast_ctrl
  import lcd_timing_pkg::*;
(
  input  wire logic       clk,               // System clock, 50 MHz
  input  wire logic       reset_n,           // Synchronous reset, active low
  input  wire logic       async_clk_in,      // External async clock pin
  input  wire logic [7:0] address,           // Register index
  input  wire logic       read,              // Read request
  input  wire logic       write,             // Write request
  input  wire logic [7:0] writedata,         // Write data
  output logic      [7:0] readdata,          // Read data
  output logic            waitrequest,       // Stall until answer
  output logic            segment_clk,       // Prescaled segment clock
  output logic            frame_start,       // One-cycle frame pulse
  output logic            driver_enable,     // LCD driver on
  output logic      [3:0] contrast_level,    // Level in use
  output logic            clock_source_sel,  // Source select in use
  output logic      [1:0] duty_sel           // Duty select in use
);

  // ****************************************
  // Decode helpers
  // ****************************************
  function automatic logic [11:0] tap_div(input logic [2:0] code);
    unique case (code)
      3'h0: tap_div = 12'd15;
      3'h1: tap_div = 12'd63;
      3'h2: tap_div = 12'd127;
      3'h3: tap_div = 12'd255;
      3'h4: tap_div = 12'd511;
      3'h5: tap_div = 12'd1023;
      3'h6: tap_div = 12'd2047;
      3'h7: tap_div = 12'd4095;
    endcase
  endfunction

  function automatic logic [15:0] drive_cycles(input logic [2:0] code);
    unique case (code)
      3'h0: drive_cycles = 16'(DRIVE_US_0 * CLK_MHZ);
      3'h1: drive_cycles = 16'(DRIVE_US_1 * CLK_MHZ);
      3'h2: drive_cycles = 16'(DRIVE_US_2 * CLK_MHZ);
      3'h3: drive_cycles = 16'(DRIVE_US_3 * CLK_MHZ);
      3'h4: drive_cycles = 16'(DRIVE_US_4 * CLK_MHZ);
      3'h5: drive_cycles = 16'(DRIVE_US_5 * CLK_MHZ);
      3'h6: drive_cycles = 16'(DRIVE_US_6 * CLK_MHZ);
      3'h7: drive_cycles = 16'hFFFF;
    endcase
  endfunction

  state_t s_reg;
  state_t s_next;

  logic       src_tick;
  logic       pre_wrap;
  logic       seg_wrap;
  logic [2:0] tap_code;
  logic [2:0] div_code;
  logic [2:0] drive_code;
  logic [1:0] duty_code;
  logic [3:0] k_last;
  logic [15:0] half_period;
  logic [15:0] drive_target;
  logic        force_half;

  assign tap_code   = s_reg.frame_rate_reg[TAP_LSB +: 3];
  assign div_code   = s_reg.frame_rate_reg[DIV_LSB +: 3];
  assign drive_code = s_reg.contrast_drive_reg[DRIVE_LSB +: 3];
  assign duty_code  = s_reg.source_cfg_reg[DUTY_LSB +: 2];
  // Source edge: system clock ticks every cycle
  assign src_tick = s_reg.source_cfg_reg[CSRC_BIT] ?
                    (s_reg.src_sync_reg & ~s_reg.src_prev_reg) : 1'b1;
  assign pre_wrap = src_tick && (s_reg.pre_cnt_reg == tap_div(tap_code));
  assign seg_wrap = pre_wrap && (s_reg.div_cnt_reg == div_code);
  assign k_last   = (duty_code == DUTY_THIRD) ? 4'(K_THIRD - 1) : 4'(K_NORMAL - 1);
  assign half_period = {1'b0, s_reg.seg_period_reg[15:1]};
  assign force_half  = (duty_code == DUTY_STATIC) || s_reg.source_cfg_reg[BLANK_BIT]
                       || (drive_code == DRIVE_HALF_CODE);
  assign drive_target = (force_half || drive_cycles(drive_code) > half_period) ?
                        half_period : drive_cycles(drive_code);

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    s_next = s_reg;
    s_next.frame_start_reg = 1'b0;
    s_next.src_meta_reg = async_clk_in;
    s_next.src_sync_reg = s_reg.src_meta_reg;
    s_next.src_prev_reg = s_reg.src_sync_reg;

    // Prescaler and divider
    if (src_tick) begin
      s_next.seg_len_reg = s_reg.seg_len_reg + 16'd1;
      if (pre_wrap) begin
        s_next.pre_cnt_reg = 12'd0;
        if (seg_wrap) begin
          s_next.div_cnt_reg = 3'd0;
        end else begin
          s_next.div_cnt_reg = s_reg.div_cnt_reg + 3'd1;
        end
      end else begin
        s_next.pre_cnt_reg = s_reg.pre_cnt_reg + 12'd1;
      end
    end else begin
      s_next.seg_len_reg = s_reg.seg_len_reg + 16'd1;
    end

    // Segment clock edge, drive window and frame count
    if (seg_wrap) begin
      s_next.seg_clk_reg    = ~s_reg.seg_clk_reg;
      s_next.seg_period_reg = s_reg.seg_len_reg + 16'd1;
      s_next.seg_len_reg    = 16'd0;
      s_next.drive_cnt_reg  = 16'd0;
      s_next.drive_en_reg   = 1'b1;
      if (s_reg.k_cnt_reg >= k_last) begin
        s_next.k_cnt_reg       = 4'd0;
        s_next.frame_start_reg = 1'b1;
        s_next.level_active_reg = s_reg.contrast_drive_reg[LEVEL_LSB +: 4];
      end else begin
        s_next.k_cnt_reg = s_reg.k_cnt_reg + 4'd1;
      end
    end else if (s_reg.contrast_drive_reg[ALWAYS_BIT]) begin
      s_next.drive_en_reg = 1'b1;
    end else begin
      if (s_reg.drive_cnt_reg != 16'hFFFF) begin
        s_next.drive_cnt_reg = s_reg.drive_cnt_reg + 16'd1;
      end
      if (s_reg.drive_cnt_reg + 16'd1 >= drive_target) begin
        s_next.drive_en_reg = 1'b0;
      end
    end

    // Avalon slave: one wait cycle, answer on second edge
    s_next.waitreq_reg = 1'b1;
    if ((read || write) && s_reg.waitreq_reg) begin
      s_next.waitreq_reg = 1'b0;
      if (write) begin
        unique case (address)
          FRAME_RATE_IDX:     s_next.frame_rate_reg = writedata & FRAME_RATE_MASK;
          CONTRAST_DRIVE_IDX: s_next.contrast_drive_reg = writedata;
          SOURCE_CFG_IDX:     s_next.source_cfg_reg = writedata & SOURCE_CFG_MASK;
          default:            s_next.rdata_reg = UNMAPPED_DATA;
        endcase
      end else begin
        unique case (address)
          FRAME_RATE_IDX:     s_next.rdata_reg = s_reg.frame_rate_reg & FRAME_RATE_MASK;
          CONTRAST_DRIVE_IDX: s_next.rdata_reg = s_reg.contrast_drive_reg;
          SOURCE_CFG_IDX:     s_next.rdata_reg = s_reg.source_cfg_reg;
          default:            s_next.rdata_reg = UNMAPPED_DATA;
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s_reg <= '0;
      s_reg.frame_rate_reg     <= FRAME_RATE_RESET;
      s_reg.contrast_drive_reg <= CONTRAST_RESET;
      s_reg.source_cfg_reg     <= SOURCE_CFG_RESET;
      s_reg.waitreq_reg        <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign readdata         = s_reg.rdata_reg;
  assign waitrequest      = s_reg.waitreq_reg;
  assign segment_clk      = s_reg.seg_clk_reg;
  assign frame_start      = s_reg.frame_start_reg;
  assign driver_enable    = s_reg.drive_en_reg;
  assign contrast_level   = s_reg.level_active_reg;
  assign clock_source_sel = s_reg.source_cfg_reg[CSRC_BIT];
  assign duty_sel         = duty_code;

  // ****************************************
  // Checks
  // ****************************************
  sequence seg_edge_s;
    seg_wrap;
  endsequence

  a_reserved_bits_zero: assert property (@(posedge clk) disable iff (!reset_n)
    (s_reg.frame_rate_reg & ~FRAME_RATE_MASK) == 8'h00)
    else $error("reserved frame rate bits set");
  a_prescale_wrap: assert property (@(posedge clk) disable iff (!reset_n)
    pre_wrap |-> s_reg.pre_cnt_reg == tap_div(tap_code))
    else $error("prescaler wrapped at wrong count");
  a_divide_wrap: assert property (@(posedge clk) disable iff (!reset_n)
    seg_wrap |-> s_reg.div_cnt_reg == div_code)
    else $error("divider wrapped at wrong count");
  a_seg_clk_toggle: assert property (@(posedge clk) disable iff (!reset_n)
    seg_edge_s |=> segment_clk != $past(segment_clk))
    else $error("segment clock did not toggle");
  a_frame_k_count: assert property (@(posedge clk) disable iff (!reset_n)
    frame_start |-> $past(s_reg.k_cnt_reg) >= k_last)
    else $error("frame ended before K segment edges");
  a_drive_cap_half: assert property (@(posedge clk) disable iff (!reset_n)
    (driver_enable && !s_reg.contrast_drive_reg[ALWAYS_BIT] && !seg_wrap)
      |-> s_reg.drive_cnt_reg < drive_target)
    else $error("drive exceeded target");
  a_always_on: assert property (@(posedge clk) disable iff (!reset_n)
    s_reg.contrast_drive_reg[ALWAYS_BIT] |=> driver_enable)
    else $error("drivers off while always-on set");
  a_level_hold: assert property (@(posedge clk) disable iff (!reset_n)
    !$past(frame_start) ##0 !frame_start |-> $stable(contrast_level))
    else $error("contrast level changed mid frame");
  a_frame_pulse: assert property (@(posedge clk) disable iff (!reset_n)
    frame_start |=> !frame_start)
    else $error("frame pulse longer than one cycle");

  // ****************************************
  // Bus checks
  // ****************************************

  sequence bus_req_s;
    (read || write) && waitrequest;
  endsequence

  sequence bus_answer_s;
    !waitrequest;
  endsequence

  a_bus_answer: assert property (@(posedge clk) disable iff (!reset_n)
    bus_req_s
      |=> bus_answer_s)
    else $error("bus request not answered after one wait cycle");

  a_bus_release: assert property (@(posedge clk) disable iff (!reset_n)
    bus_answer_s
      |=> waitrequest)
    else $error("waitrequest low for more than one cycle");

  a_idle_wait: assert property (@(posedge clk) disable iff (!reset_n)
    !(read || write)
      |=> waitrequest)
    else $error("waitrequest low without a request");

  a_rdata_quiet: assert property (@(posedge clk) disable iff (!reset_n)
    !$stable(readdata)
      |-> bus_answer_s)
    else $error("read data changed outside an answer");

  a_reserved_read: assert property (@(posedge clk) disable iff (!reset_n)
    bus_answer_s ##0 $past(read && address == FRAME_RATE_IDX)
      |-> (readdata & ~FRAME_RATE_MASK) == 8'h00)
    else $error("reserved frame rate bits read nonzero");

  a_unmapped_read: assert property (@(posedge clk) disable iff (!reset_n)
    bus_answer_s ##0 $past(read && address != FRAME_RATE_IDX
      && address != CONTRAST_DRIVE_IDX && address != SOURCE_CFG_IDX)
      |-> readdata == UNMAPPED_DATA)
    else $error("unmapped read returned data");

  a_frame_write: assert property (@(posedge clk) disable iff (!reset_n)
    bus_answer_s ##0 $past(write && address == FRAME_RATE_IDX)
      |-> s_reg.frame_rate_reg == ($past(writedata) & FRAME_RATE_MASK))
    else $error("frame rate write did not land");

  a_contrast_write: assert property (@(posedge clk) disable iff (!reset_n)
    bus_answer_s ##0 $past(write && address == CONTRAST_DRIVE_IDX)
      |-> s_reg.contrast_drive_reg == $past(writedata))
    else $error("contrast write did not land");

  a_cfg_mask: assert property (@(posedge clk) disable iff (!reset_n)
    1'b1
      |-> (s_reg.source_cfg_reg & ~SOURCE_CFG_MASK) == 8'h00)
    else $error("reserved source config bits set");

  // ****************************************
  // Clock checks
  // ****************************************

  a_sys_tick: assert property (@(posedge clk) disable iff (!reset_n)
    !clock_source_sel
      |-> src_tick)
    else $error("system clock source missed a tick");

  a_async_rate: assert property (@(posedge clk) disable iff (!reset_n)
    clock_source_sel && src_tick ##1 clock_source_sel
      |-> !src_tick)
    else $error("async source ticked on consecutive cycles");

  a_frame_after_edge: assert property (@(posedge clk) disable iff (!reset_n)
    frame_start
      |-> $past(seg_wrap))
    else $error("frame pulse without segment edge");

  a_k_below_limit: assert property (@(posedge clk) disable iff (!reset_n)
    1'b1
      |-> s_reg.k_cnt_reg <= 4'(K_NORMAL - 1))
    else $error("frame counter beyond K");

  a_seg_len_clear: assert property (@(posedge clk) disable iff (!reset_n)
    seg_edge_s
      |=> s_reg.seg_len_reg == 16'h0000)
    else $error("segment period measure not restarted");

  a_level_on_frame: assert property (@(posedge clk) disable iff (!reset_n)
    frame_start
      |-> contrast_level == $past(s_reg.contrast_drive_reg[LEVEL_LSB +: 4]))
    else $error("contrast level not taken at frame start");

  // ****************************************
  // Drive checks
  // ****************************************

  sequence drive_start_s;
    seg_wrap ##1 driver_enable;
  endsequence

  a_drive_starts: assert property (@(posedge clk) disable iff (!reset_n)
    drive_start_s
      |-> s_reg.drive_cnt_reg == 16'h0000)
    else $error("drive window did not start at segment edge");

  a_drive_ends: assert property (@(posedge clk) disable iff (!reset_n)
    driver_enable && !s_reg.contrast_drive_reg[ALWAYS_BIT] && !seg_wrap
      && (s_reg.drive_cnt_reg + 16'h0001 >= drive_target)
      |=> !driver_enable)
    else $error("drive window overran its target");

  a_off_stays: assert property (@(posedge clk) disable iff (!reset_n)
    !driver_enable && !seg_wrap && !s_reg.contrast_drive_reg[ALWAYS_BIT]
      |=> !driver_enable)
    else $error("drivers turned on between segment edges");

endmodule
`default_nettype wire

// >>> core/lcd_timing_pkg.sv
package lcd_timing_pkg;

  // ****************************************
  // Register map (byte offsets are indices)
  // ****************************************
  localparam logic [7:0] FRAME_RATE_IDX     = 8'hE6;
  localparam logic [7:0] CONTRAST_DRIVE_IDX = 8'hE7;
  localparam logic [7:0] SOURCE_CFG_IDX     = 8'hE8;
  localparam logic [7:0] FRAME_RATE_RESET   = 8'h00;
  localparam logic [7:0] CONTRAST_RESET     = 8'h00;
  localparam logic [7:0] SOURCE_CFG_RESET   = 8'h00;
  localparam logic [7:0] FRAME_RATE_MASK    = 8'h77;
  localparam logic [7:0] SOURCE_CFG_MASK    = 8'h0F;
  localparam logic [7:0] UNMAPPED_DATA      = 8'h00;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int TAP_LSB    = 4;
  localparam int DIV_LSB    = 0;
  localparam int DRIVE_LSB  = 5;
  localparam int ALWAYS_BIT = 4;
  localparam int LEVEL_LSB  = 0;
  localparam int CSRC_BIT   = 0;
  localparam int BLANK_BIT  = 1;
  localparam int DUTY_LSB   = 2;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_MHZ = 50;
  localparam int DRIVE_US_0 = 300;
  localparam int DRIVE_US_1 = 70;
  localparam int DRIVE_US_2 = 150;
  localparam int DRIVE_US_3 = 450;
  localparam int DRIVE_US_4 = 575;
  localparam int DRIVE_US_5 = 850;
  localparam int DRIVE_US_6 = 1150;
  localparam int K_NORMAL = 8;
  localparam int K_THIRD  = 6;

  localparam logic [1:0] DUTY_STATIC  = 2'h0;
  localparam logic [1:0] DUTY_HALF    = 2'h1;
  localparam logic [1:0] DUTY_THIRD   = 2'h2;
  localparam logic [1:0] DUTY_QUARTER = 2'h3;
  localparam logic [2:0] DRIVE_HALF_CODE = 3'h7;

  localparam int MV_BASE = 2600;
  localparam int MV_STEP = 50;

  typedef struct packed {
    logic [7:0]  frame_rate_reg;
    logic [7:0]  contrast_drive_reg;
    logic [7:0]  source_cfg_reg;
    logic [3:0]  level_active_reg;
    logic        src_meta_reg;
    logic        src_sync_reg;
    logic        src_prev_reg;
    logic [11:0] pre_cnt_reg;
    logic [2:0]  div_cnt_reg;
    logic        seg_clk_reg;
    logic [15:0] seg_period_reg;
    logic [15:0] seg_len_reg;
    logic [15:0] drive_cnt_reg;
    logic        drive_en_reg;
    logic [3:0]  k_cnt_reg;
    logic        frame_start_reg;
    logic        waitreq_reg;
    logic [7:0]  rdata_reg;
  } state_t;

endpackage

// >>> testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import lcd_timing_pkg::*;
  logic       clk, reset_n, async_clk_in, read, write;
  logic [7:0] address, writedata, readdata, rd;
  logic       waitrequest, segment_clk, frame_start, driver_enable, clock_source_sel;
  logic [3:0] contrast_level;
  logic [1:0] duty_sel;
  int         mismatches, n_checks, n, i;
  lcd_frame_rate_contrast_ctrl lcd_frame_rate_contrast_ctrl_i (
    .clk(clk), .reset_n(reset_n), .async_clk_in(async_clk_in), .address(address),
    .read(read), .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .segment_clk(segment_clk), .frame_start(frame_start),
    .driver_enable(driver_enable), .contrast_level(contrast_level),
    .clock_source_sel(clock_source_sel), .duty_sel(duty_sel));
  // ****************************************
  // Clocks and watchdog
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    async_clk_in = 1'b0;
    #7;
    forever #60 async_clk_in = ~async_clk_in;
  end
  initial begin
    repeat (95000) @(posedge clk);
    mismatches++;
    $display("Error at %0t: watchdog expired", $time);
    final_report();
  end
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
    int g;
    g = 0;
    @(posedge clk);
    address   <= a;
    writedata <= d;
    read      <= ~wr;
    write     <= wr;
    do begin
      @(posedge clk);
      g++;
    end while (waitrequest !== 1'b0 && g < 50);
    rd = readdata;
    check(g < 50, 1'b1, "bus answer");
    read  <= 1'b0;
    write <= 1'b0;
  endtask
  // Cycles to next frame pulse (sel 0) or segment toggle (sel 1)
  task automatic gap(input int sel, output int cnt);
    logic prev, hit;
    prev = segment_clk;
    cnt  = 0;
    do begin
      @(posedge clk);
      cnt++;
      hit  = sel ? (segment_clk !== prev) : (frame_start === 1'b1);
      prev = segment_clk;
    end while (!hit && cnt < 20000);
  endtask
  task automatic rate(input logic [7:0] fr, cfg, input int tog, frm);
    bus(1, FRAME_RATE_IDX, fr);
    bus(1, SOURCE_CFG_IDX, cfg);
    gap(0, n);
    gap(0, n);
    check(n, frm, "frame spacing");
    gap(1, n);
    gap(1, n);
    check(n, tog, "segment toggle spacing");
    check({duty_sel, clock_source_sel}, {cfg[3:2], cfg[0]}, "source config");
    $display("rate test %h %h done", fr, cfg);
  endtask
  task automatic drive(input logic [7:0] fr, cc, cfg, input int span, exp);
    int hi;
    hi = 0;
    bus(1, FRAME_RATE_IDX, fr);
    bus(1, CONTRAST_DRIVE_IDX, cc);
    bus(1, SOURCE_CFG_IDX, cfg);
    gap(1, n);
    gap(1, n);
    repeat (span) begin
      @(posedge clk);
      hi += (driver_enable === 1'b1);
    end
    check(hi >= exp - 1 && hi <= exp + 1, 1'b1, "drive on time");
    $display("drive test %h %h done", cc, cfg);
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    mismatches = 0;
    n_checks   = 0;
    reset_n    = 1'b0;
    read       = 1'b0;
    write      = 1'b0;
    address    = 8'h00;
    writedata  = 8'h00;
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    bus(0, FRAME_RATE_IDX, 8'h00);
    check(rd, FRAME_RATE_RESET, "frame rate reset");
    bus(0, CONTRAST_DRIVE_IDX, 8'h00);
    check(rd, CONTRAST_RESET, "contrast reset");
    bus(1, 8'h10, 8'h55);
    bus(0, 8'h10, 8'h00);
    check(rd, UNMAPPED_DATA, "unmapped read");
    bus(1, FRAME_RATE_IDX, 8'hFF);
    bus(0, FRAME_RATE_IDX, 8'h00);
    check(rd, 8'h77, "reserved bits");
    $display("register test done");
    rate(8'h00, 8'h00, 16, 128);
    rate(8'h01, 8'h0C, 32, 256);
    rate(8'h10, 8'h04, 64, 512);
    rate(8'h07, 8'h0C, 128, 1024);
    rate(8'h00, 8'h08, 16, 96);
    rate(8'h00, 8'h01, 96, 768);
    bus(1, SOURCE_CFG_IDX, 8'h0C);
    for (i = 0; i < 2; i++) begin
      gap(0, n);
      bus(1, CONTRAST_DRIVE_IDX, 8'h05 + 8'h0A * i);
      check(contrast_level, 4'h0 + 4'h5 * i, "level held");
      gap(0, n);
      #1;
      check(contrast_level, 4'h5 + 4'hA * i, "level applied");
    end
    bus(0, CONTRAST_DRIVE_IDX, 8'h00);
    check(rd, 8'h0F, "contrast readback");
    $display("contrast test done");
    drive(8'h00, 8'h00, 8'h0C, 16, 8);
    drive(8'h00, 8'hE0, 8'h0C, 16, 8);
    drive(8'h00, 8'h10, 8'h0C, 16, 16);
    drive(8'h71, 8'h20, 8'h0C, 8192, 3500);
    drive(8'h71, 8'h20, 8'h0E, 8192, 4096);
    final_report();
  end
endmodule
`default_nettype wire
